/* core/cycle_if.sv */
// decoded host i/o cycle, passed from the decoder to the control core
// assumes all members are on clk and derived from synchronised pins
`timescale 1ns/1ps
interface cycle_if;
  import pc_io_pkg::*;
  logic       reg_rd;
  logic       reg_wr;
  logic       id_rd;
  logic       id_wr;
  logic       card_hit;
  lane_mode_t lane;
  logic       addr0;
  logic [4:0] base;
  logic [1:0] be;
  logic [7:0] wr_even;
  logic [7:0] wr_odd;
  modport dec  (output reg_rd, reg_wr, id_rd, id_wr, card_hit, lane, addr0, base, be,
                wr_even, wr_odd);
  modport core (input reg_rd, reg_wr, id_rd, id_wr, card_hit, lane, addr0, base, be,
                wr_even, wr_odd);
endinterface

/* core/pc_card_io_space_control.sv */
// pc card i/o window: register forwarding, id rom strobes, card control
// register, card resets and power mode outputs for the lan controller
// assumes the lan controller and configuration logic share clk
`timescale 1ns/1ps
// Operation
// - 8-bit access: ce1 low, ce2 high, a0 picks byte, low lane only.
// - word access both enables low; ce2-only moves even byte on high lane.
// - i/o cycles at 0 to 10h reach registers, rom pins stay idle.
// - id reads at even 12h..1eh drive rom select, read low, address high.
// - id writes need iowr and we; rom select low, others high.
// - 8-bit card control register at 10h, reset to zero.
// - bit 7 permits writes to card attribute information.
// - bit 6 permits writes to common memory.
// - bit 5 permits writes to id number space.
// - bits 0 to 4 read zero and ignore writes.
// - after insertion or any reset the memory-only interface is presented.
// - hardware reset clears configuration, interface mode, lan and transceiver.
// - soft reset bit acts like hardware reset but stays set itself.
// - link hold bit initialises lan keeping registers, powers down transceiver.
// - standby 0 with deep select 0 stops clocks, oscillator runs.
// - standby 0 with deep select 1 stops the oscillator.
// - standby bit is set automatically in pc card mode.
// - standby follows config power-down; software cannot change it.
module pc_card_io_space_control (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  input  wire logic                         hard_reset,
  input  wire logic                         host_reg_n,
  input  wire logic                         host_ce1_n,
  input  wire logic                         host_ce2_n,
  input  wire logic                         host_iord_n,
  input  wire logic                         host_iowr_n,
  input  wire logic                         host_we_n,
  input  wire logic [pc_io_pkg::ADDR_W-1:0] host_addr,
  input  wire logic [pc_io_pkg::DATA_W-1:0] host_data_in,
  output logic      [pc_io_pkg::DATA_W-1:0] host_data_out,
  output logic                              host_data_oe_n,
  output logic                              rom_select_out,
  output logic                              rom_read_strobe,
  output logic                              rom_address_control,
  input  wire logic                         cfg_io_select,
  input  wire logic                         soft_card_reset,
  input  wire logic                         config_power_down,
  output logic                              io_card_active,
  output logic                              ccr_init,
  output logic                              ccr_init_keep_soft,
  output logic                              ctl_rd_pulse,
  output logic                              ctl_wr_pulse,
  output logic      [pc_io_pkg::CTL_AW-1:0] ctl_addr,
  output logic      [1:0]                   ctl_be,
  output logic      [pc_io_pkg::DATA_W-1:0] ctl_wdata,
  input  wire logic [pc_io_pkg::DATA_W-1:0] ctl_rdata,
  output logic                              attr_info_write_permit,
  output logic                              common_mem_write_permit,
  output logic                              id_space_write_permit,
  output logic                              link_ctrl_hold,
  output logic                              standby_bit,
  output logic                              lan_init,
  output logic                              xcvr_init,
  output logic                              xcvr_power_down,
  output logic                              clock_stop,
  output logic                              osc_stop
);
  import pc_io_pkg::*;

  localparam int PIN_W = 6 + ADDR_W + DATA_W;

  logic [PIN_W-1:0]  pins_raw;
  logic [PIN_W-1:0]  pins_s;
  logic              hard_s;
  logic              s_reg_n;
  logic              s_ce1_n;
  logic              s_ce2_n;
  logic              s_iord_n;
  logic              s_iowr_n;
  logic              s_we_n;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;

  cycle_if cyc ();

  cyc_state_t  state_reg;
  cyc_state_t  state_next;
  logic        io_active_reg;
  logic [7:0]  card_ctrl_reg;
  logic        hold_reg;
  logic        deep_reg;
  logic        standby_reg;
  logic        card_reset;
  logic        any_cycle;
  logic        issue_rd;
  logic        issue_wr;
  logic        card_we;
  logic        ctl_hit_wr;
  logic        id_permit;
  logic [7:0]  odd_fixed;
  logic [15:0] rd_word;
  logic [15:0] rd_lanes;
  logic        rom_select_out_next;
  logic        rom_read_strobe_next;
  logic        rom_address_control_next;

  assign pins_raw = {host_reg_n, host_ce1_n, host_ce2_n, host_iord_n, host_iowr_n,
                     host_we_n, host_addr, host_data_in};

  pin_sync #(
    .WIDTH (PIN_W),
    .INIT  ({PIN_IDLE, {(ADDR_W + DATA_W){1'b0}}})
  ) u_pin_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .d      (pins_raw),
    .q      (pins_s)
  );

  pin_sync #(
    .WIDTH (1),
    .INIT  (1'b0)
  ) u_reset_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .d      (hard_reset),
    .q      (hard_s)
  );

  assign {s_reg_n, s_ce1_n, s_ce2_n, s_iord_n, s_iowr_n, s_we_n, s_addr, s_data} = pins_s;

  pc_io_decode u_decode (
    .addr      (s_addr),
    .data      (s_data),
    .reg_n     (s_reg_n),
    .ce1_n     (s_ce1_n),
    .ce2_n     (s_ce2_n),
    .iord_n    (s_iord_n),
    .iowr_n    (s_iowr_n),
    .we_n      (s_we_n),
    .io_active (io_active_reg),
    .cyc       (cyc.dec)
  );

  // soft reset is a level from the configuration logic; it keeps its own bit
  assign card_reset = hard_s || soft_card_reset;
  assign any_cycle  = cyc.reg_rd || cyc.reg_wr || cyc.id_rd || cyc.id_wr;
  assign issue_rd   = state_reg == ST_IDLE && cyc.reg_rd;
  assign issue_wr   = state_reg == ST_IDLE && cyc.reg_wr;
  assign card_we    = issue_wr && cyc.card_hit && cyc.be[0];
  assign ctl_hit_wr = issue_wr && !cyc.card_hit;
  assign id_permit  = card_ctrl_reg[ID_PERMIT_BIT];

  // the standby field of link register 7 is overwritten on its way out
  always_comb
  begin
    odd_fixed = cyc.wr_odd;
    if (cyc.base[3:0] == OFS_LINK6)
      odd_fixed[STANDBY_BIT] = standby_reg;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (cyc.reg_rd || cyc.reg_wr) state_next = ST_ISSUE;
                else if (any_cycle)           state_next = ST_HOLD;
      ST_ISSUE: state_next = cyc.reg_rd ? ST_FETCH : ST_HOLD;
      ST_FETCH: state_next = ST_HOLD;
      ST_HOLD:  if (!any_cycle) state_next = ST_IDLE;
    endcase
  end

  assign rd_word  = cyc.card_hit ? {8'h00, card_ctrl_reg} : ctl_rdata;
  assign rd_lanes = cyc.lane == LANE_WORD ? rd_word :
                    cyc.lane == LANE_HIGH ? {rd_word[7:0], 8'h00} :
                    {8'h00, cyc.addr0 ? rd_word[15:8] : rd_word[7:0]};

  // rom pins idle for register cycles; a blocked id write leaves them idle
  assign rom_select_out_next  = !(cyc.id_rd || (cyc.id_wr && id_permit));
  assign rom_read_strobe_next = !cyc.id_rd;
  assign rom_address_control_next = cyc.id_rd || (cyc.id_wr && id_permit);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_IDLE;
    else if (clk_en)
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_active_reg <= 1'b0;
      card_ctrl_reg <= CARD_CTRL_RESET;
    end
    else if (clk_en)
    begin
      if (card_reset)
      begin
        io_active_reg <= 1'b0;
        card_ctrl_reg <= CARD_CTRL_RESET;
      end
      else
      begin
        if (cfg_io_select)
          io_active_reg <= 1'b1;
        if (card_we)
          card_ctrl_reg <= cyc.wr_even & CARD_CTRL_MASK;
      end
    end
  end

  // hold and deep select are shadows of writes bound for the lan controller
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_reg <= 1'b0;
      deep_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (card_reset)
      begin
        hold_reg <= 1'b0;
        deep_reg <= 1'b0;
      end
      else if (ctl_hit_wr && cyc.be[0])
      begin
        if (cyc.base[3:0] == OFS_LINK6)
          hold_reg <= cyc.wr_even[LINK_HOLD_BIT];
        if (cyc.base[3:0] == OFS_BUF14)
          deep_reg <= cyc.wr_even[DEEP_SEL_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      standby_reg <= STANDBY_RESET;
    else if (clk_en)
      standby_reg <= !config_power_down;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_rd_pulse <= 1'b0;
      ctl_wr_pulse <= 1'b0;
      ctl_addr     <= '0;
      ctl_be       <= '0;
      ctl_wdata    <= '0;
    end
    else if (clk_en)
    begin
      ctl_rd_pulse <= issue_rd && !cyc.card_hit;
      ctl_wr_pulse <= ctl_hit_wr;
      if (issue_rd || issue_wr)
      begin
        ctl_addr  <= cyc.base[3:0];
        ctl_be    <= cyc.be;
        ctl_wdata <= {odd_fixed, cyc.wr_even};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      host_data_out <= '0;
    else if (clk_en && state_reg == ST_FETCH)
      host_data_out <= rd_lanes;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rom_select_out      <= 1'b1;
      rom_read_strobe     <= 1'b1;
      rom_address_control <= 1'b0;
    end
    else if (clk_en)
    begin
      rom_select_out      <= rom_select_out_next;
      rom_read_strobe     <= rom_read_strobe_next;
      rom_address_control <= rom_address_control_next;
    end
  end

  // power and reset outputs are registered to keep glitches off the lan core
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ccr_init           <= 1'b0;
      ccr_init_keep_soft <= 1'b0;
      lan_init           <= 1'b0;
      xcvr_init          <= 1'b0;
      xcvr_power_down    <= 1'b0;
      clock_stop         <= 1'b0;
      osc_stop           <= 1'b0;
    end
    else if (clk_en)
    begin
      ccr_init           <= card_reset;
      ccr_init_keep_soft <= soft_card_reset && !hard_s;
      lan_init           <= card_reset || hold_reg;
      xcvr_init          <= card_reset;
      xcvr_power_down    <= hold_reg;
      clock_stop         <= !standby_reg && !deep_reg;
      osc_stop           <= !standby_reg && deep_reg;
    end
  end

  // drive only once the captured word is on the flops; id reads belong to the rom
  assign host_data_oe_n = !(state_reg == ST_HOLD && cyc.reg_rd);
  assign io_card_active          = io_active_reg;
  assign attr_info_write_permit  = card_ctrl_reg[ATTR_PERMIT_BIT];
  assign common_mem_write_permit = card_ctrl_reg[COMMON_PERMIT_BIT];
  assign id_space_write_permit   = id_permit;
  assign link_ctrl_hold          = hold_reg;
  assign standby_bit             = standby_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_ID_READ_ROM: assert property (clk_en && cyc.id_rd |=>
    !rom_select_out && !rom_read_strobe && rom_address_control)
    else $error("id read did not drive rom pins");
  AST_REG_ROM_IDLE: assert property (clk_en && (cyc.reg_rd || cyc.reg_wr) |=>
    rom_select_out && rom_read_strobe && !rom_address_control)
    else $error("rom pins active during register cycle");
  AST_ID_WRITE_ROM: assert property (clk_en && cyc.id_wr && id_permit |=>
    !rom_select_out && rom_read_strobe && rom_address_control)
    else $error("permitted id write wrong rom pins");
  AST_ID_WRITE_BLOCKED: assert property (clk_en && cyc.id_wr && !id_permit |=>
    rom_select_out && !rom_address_control)
    else $error("blocked id write reached the rom");
  AST_CARD_LOW_ZERO: assert property (card_ctrl_reg[4:0] == 5'h00)
    else $error("card control low bits not zero");
  AST_CARD_WRITE: assert property (clk_en && card_we && !card_reset |=>
    card_ctrl_reg == ($past(cyc.wr_even) & CARD_CTRL_MASK))
    else $error("card control write lost");
  AST_RESET_CLEARS: assert property (clk_en && card_reset |=>
    !io_active_reg && card_ctrl_reg == 8'h00 && ccr_init)
    else $error("card reset did not clear state");
  AST_STANDBY_FOLLOW: assert property (clk_en |=>
    standby_reg == !$past(config_power_down))
    else $error("standby does not follow power down");
  AST_MEM_MODE_DARK: assert property (!io_active_reg |->
    !cyc.reg_rd && !cyc.reg_wr && !cyc.id_rd && !cyc.id_wr)
    else $error("decode active in memory-only mode");
  AST_HOLD_INIT: assert property (clk_en && hold_reg |=>
    lan_init && xcvr_power_down)
    else $error("link hold did not init lan");
  AST_POWER_MODES: assert property (clk_en && !standby_reg |=>
    clock_stop == !$past(deep_reg) && osc_stop == $past(deep_reg))
    else $error("power mode outputs wrong");

  COV_ID_READ: cover property (clk_en && cyc.id_rd ##1 !rom_select_out);
  COV_CARD_WRITE: cover property (card_we && cyc.wr_even[ID_PERMIT_BIT]);
  COV_WORD_READ: cover property (state_reg == ST_FETCH && cyc.lane == LANE_WORD);
endmodule

/* core/pc_io_decode.sv */
// decodes synchronised pc card i/o pins into one cycle description
// assumes pins are already two-flop synchronised and active low
`timescale 1ns/1ps
module pc_io_decode (
  input  wire logic [pc_io_pkg::ADDR_W-1:0] addr,
  input  wire logic [pc_io_pkg::DATA_W-1:0] data,
  input  wire logic                         reg_n,
  input  wire logic                         ce1_n,
  input  wire logic                         ce2_n,
  input  wire logic                         iord_n,
  input  wire logic                         iowr_n,
  input  wire logic                         we_n,
  input  wire logic                         io_active,
  cycle_if.dec                              cyc
);
  import pc_io_pkg::*;

  lane_mode_t lane;
  logic       sel;
  logic       rd;
  logic       wr;
  logic       is_ctl;
  logic       is_id;
  logic [4:0] base;

  assign lane   = lane_of(ce1_n, ce2_n);
  assign base   = {addr[4:1], 1'b0};
  // memory-only interface keeps the whole window dark
  assign sel    = !reg_n && lane != LANE_NONE && io_active;
  assign rd     = sel && !iord_n && iowr_n;
  assign wr     = sel && !iowr_n && iord_n;
  assign is_ctl = !addr[4];
  assign is_id  = base >= OFS_ID_LO && base <= OFS_ID_HI && !addr[0];

  assign cyc.lane     = lane;
  assign cyc.addr0    = addr[0];
  assign cyc.base     = base;
  assign cyc.card_hit = base == OFS_CARD_CTRL;
  assign cyc.reg_rd   = rd && (is_ctl || cyc.card_hit);
  assign cyc.reg_wr   = wr && (is_ctl || cyc.card_hit);
  assign cyc.id_rd    = rd && is_id;
  assign cyc.id_wr    = wr && !we_n && is_id;

  // byte access uses the low lane, high-only carries the even byte up top
  assign cyc.be = lane == LANE_WORD ? 2'b11 :
                  lane == LANE_HIGH ? 2'b01 :
                  lane == LANE_BYTE ? (addr[0] ? 2'b10 : 2'b01) :
                  2'b00;
  assign cyc.wr_even = lane == LANE_HIGH ? data[15:8] : data[7:0];
  assign cyc.wr_odd  = lane == LANE_WORD ? data[15:8] : data[7:0];
endmodule

/* core/pc_io_pkg.sv */
// constants, types and lane decoding for the pc card i/o window
// assumes a 32-byte i/o window addressed by five host address bits
package pc_io_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int CTL_AW = 4;

  localparam logic [4:0] OFS_CARD_CTRL = 5'h10;
  localparam logic [4:0] OFS_ID_LO     = 5'h12;
  localparam logic [4:0] OFS_ID_HI     = 5'h1e;

  localparam int ATTR_PERMIT_BIT   = 7;
  localparam int COMMON_PERMIT_BIT = 6;
  localparam int ID_PERMIT_BIT     = 5;
  localparam logic [7:0] CARD_CTRL_RESET = 8'h00;
  localparam logic [7:0] CARD_CTRL_MASK  = 8'he0;

  localparam logic [3:0] OFS_LINK6 = 4'h6;
  localparam logic [3:0] OFS_BUF14 = 4'he;
  localparam int LINK_HOLD_BIT = 7;
  localparam int STANDBY_BIT   = 5;
  localparam int DEEP_SEL_BIT  = 4;
  localparam logic STANDBY_RESET = 1'b1;

  localparam logic [5:0] PIN_IDLE = 6'h3f;

  typedef enum logic [1:0] {
    LANE_NONE = 2'b00,
    LANE_BYTE = 2'b01,
    LANE_WORD = 2'b10,
    LANE_HIGH = 2'b11
  } lane_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_FETCH = 2'b10,
    ST_HOLD  = 2'b11
  } cyc_state_t;

  function automatic lane_mode_t lane_of(input logic ce1_n, input logic ce2_n);
    unique case ({ce2_n, ce1_n})
      2'b10:   lane_of = LANE_BYTE;
      2'b00:   lane_of = LANE_WORD;
      2'b01:   lane_of = LANE_HIGH;
      default: lane_of = LANE_NONE;
    endcase
  endfunction

endpackage

/* core/pin_sync.sv */
// two-flop synchroniser for a bundle of host pins
// assumes the bundle is sampled only while clk_en is high
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync width must be at least one");
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= INIT;
      q        <= INIT;
    end
    else if (clk_en)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

/* sim/host_socket_model.sv */
// host socket model: runs one pc card i/o cycle per call
// assumes the card answers on dout while the strobes are held
`timescale 1ns/1ps
module host_socket_model (
  input  wire logic        clk,
  input  wire logic [15:0] dout,
  input  wire logic        oe_n,
  output logic             reg_n,
  output logic             ce1_n,
  output logic             ce2_n,
  output logic             iord_n,
  output logic             iowr_n,
  output logic             we_n,
  output logic [4:0]       addr,
  output logic [15:0]      data
);
  initial
  begin
    {reg_n, ce1_n, ce2_n, iord_n, iowr_n, we_n} = 6'h3f;
    addr = 5'h00;
    data = 16'h0000;
  end
  // m: 0 byte, 1 word, 2 high byte only
  task automatic io(input logic wr, we, input logic [1:0] m, input logic [4:0] a,
                    input logic [15:0] d, output logic [15:0] q, output logic ok);
    int n;
    @(negedge clk);
    reg_n = 1'b0;
    ce1_n = (m == 2'd2);
    ce2_n = (m == 2'd0);
    {addr, data, iord_n, iowr_n} = {a, d, wr, !wr};
    we_n = !we;
    n = 0;
    while (oe_n !== 1'b0 && n < 9)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    {ok, q} = {oe_n === 1'b0, dout};
    {reg_n, ce1_n, ce2_n, iord_n, iowr_n, we_n} = 6'h3f;
    data = ~d; // a released bus must not echo the last value
    repeat (4) @(negedge clk);
  endtask
endmodule

/* sim/pc_card_io_space_control_bench.sv */
// self-checking bench for the pc card i/o window control
// assumes host_socket_model plays the socket; controller read data is modelled here
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pc_card_io_space_control_bench;
  import pc_io_pkg::*;
  logic        clk, rst_n, hard_reset, cfg_io_select, soft_card_reset, config_power_down;
  logic        reg_n, ce1_n, ce2_n, iord_n, iowr_n, we_n, oe_n, ok;
  logic        io_card_active, ccr_init, ccr_init_keep_soft, ctl_rd_pulse, ctl_wr_pulse;
  logic        link_ctrl_hold, standby_bit, lan_init, xcvr_init, xcvr_power_down;
  logic        clock_stop, osc_stop, rom_select_out, rom_read_strobe, rom_address_control;
  logic [1:0]  ctl_be, wbe, m;
  logic [2:0]  perm, r;
  logic [3:0]  ctl_addr, wad;
  logic [4:0]  addr, a;
  logic [15:0] din, dout, ctl_wdata, wdat, q, w, ctl_rdata = 16'h0000;
  logic [33:0] p;
  int          errors, checked, wrs, rds, c0;
  wire  [2:0]  rom = {rom_select_out, rom_read_strobe, rom_address_control};
  wire  [15:0] wm = {{8{p[33]}}, {8{p[32]}}};

  host_socket_model host_socket_model_inst (.clk, .dout, .oe_n, .reg_n, .ce1_n, .ce2_n,
    .iord_n, .iowr_n, .we_n, .addr, .data(din));
  pc_card_io_space_control pc_card_io_space_control_inst (.clk, .rst_n, .clk_en(1'b1),
    .hard_reset, .host_reg_n(reg_n), .host_ce1_n(ce1_n), .host_ce2_n(ce2_n),
    .host_iord_n(iord_n), .host_iowr_n(iowr_n), .host_we_n(we_n), .host_addr(addr),
    .host_data_in(din), .host_data_out(dout), .host_data_oe_n(oe_n), .rom_select_out,
    .rom_read_strobe, .rom_address_control, .cfg_io_select, .soft_card_reset,
    .config_power_down, .io_card_active, .ccr_init, .ccr_init_keep_soft, .ctl_rd_pulse,
    .ctl_wr_pulse, .ctl_addr, .ctl_be, .ctl_wdata, .ctl_rdata,
    .attr_info_write_permit(perm[2]), .common_mem_write_permit(perm[1]),
    .id_space_write_permit(perm[0]), .link_ctrl_hold, .standby_bit, .lan_init, .xcvr_init,
    .xcvr_power_down, .clock_stop, .osc_stop);

  // controller registers: bit 5 of the odd byte kept 1 to match the standby overlay
  function automatic logic [15:0] rdm(input logic [3:0] b);
    rdm = {4'hb, b, 4'h6, b};
  endfunction
  // word to pins: {byte enables, lane mask, lanes}
  function automatic logic [33:0] pin(input logic [1:0] k, input logic a0,
                                      input logic [15:0] v);
    case (k)
      2'd0:    pin = a0 ? {2'b10, 16'h00ff, 8'h00, v[15:8]} : {2'b01, 16'h00ff, 8'h00, v[7:0]};
      2'd1:    pin = {2'b11, 16'hffff, v};
      default: pin = {2'b01, 16'hff00, v[7:0], 8'h00};
    endcase
  endfunction

  always @(negedge clk)
    ctl_rdata <= rdm(ctl_addr);
  // pulses stand one full cycle, so the falling edge sees each exactly once
  always @(negedge clk)
  begin
    if (ctl_wr_pulse === 1'b1)
    begin
      wrs++;
      {wbe, wad, wdat} = {ctl_be, ctl_addr, ctl_wdata};
    end
    if (ctl_rd_pulse === 1'b1)
      rds++;
  end

  task automatic cyc(input logic wr, we, input logic [1:0] k, input logic [4:0] x,
                     input logic [15:0] d);
    fork
      host_socket_model_inst.io(wr, we, k, x, d, q, ok);
      begin
        repeat (6) @(negedge clk);
        r = rom;
      end
    join
  endtask
  task automatic creg(input logic [7:0] v, input logic [7:0] e);
    cyc(1'b1, 1'b0, 2'd0, 5'h10, {~v, v});
    cyc(1'b0, 1'b0, 2'd0, 5'h10, 16'h0000);
    `CHK("card_ctrl", e, q[7:0])
    `CHK("permits", e[7:5], perm)
  endtask
  task automatic enter();
    cfg_io_select = 1'b1;
    @(negedge clk);
    cfg_io_select = 1'b0;
    @(negedge clk);
    `CHK("io_active", 1'b1, io_card_active)
  endtask
  task automatic complete_run();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    complete_run();
  end

  initial
  begin
    {rst_n, hard_reset, cfg_io_select, soft_card_reset, config_power_down} = 5'h00;
    {errors, checked, wrs, rds} = '0;
    void'($urandom(99));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    `CHK("reset", 9'h01b, {io_card_active, perm, rom, standby_bit, oe_n})
    // memory-only interface: the window must stay deaf
    cyc(1'b1, 1'b0, 2'd0, 5'h10, 16'h00ff);
    cyc(1'b0, 1'b0, 2'd1, 5'h00, 16'h0000);
    `CHK("memonly", 12'h000, {ok, perm, 8'(wrs + rds)})
    enter();
    for (int i = 4; i < 8; i++)
      creg(8'h1f | (8'h01 << i), (8'h01 << i) & 8'he0);
    creg(8'hff, 8'he0);
    creg(8'h00, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      m = 2'($urandom_range(0, 2));
      a = 5'($urandom_range(0, 15));
      // keep off the hold, standby and deep select shadows at 6 and e
      if (a[2:1] == 2'd3)
        a[2] = 1'b0;
      w = 16'($urandom);
      p = pin(m, a[0], i[0] ? rdm({a[3:1], 1'b0}) : w);
      c0 = wrs + rds;
      cyc(!i[0], 1'b0, m, a, p[15:0] | (~p[31:16] & 16'($urandom)));
      `CHK("ctl_pulse", c0 + 1, wrs + rds)
      `CHK("rom_idle", 3'b110, r)
      if (i[0])
        `CHK("rd_data", {1'b1, p[15:0]}, {ok, q & p[31:16]})
      else
        `CHK("wr", {p[33:32], a[3:1], 1'b0, w & wm}, {wbe, wad, wdat & wm})
    end
    for (int i = 'h12; i < 'h20; i += 2)
    begin
      cyc(1'b0, 1'b0, 2'(i[1]), 5'(i), 16'h0000);
      `CHK("id_read", 3'b001, r)
      cyc(1'b1, 1'b1, 2'd0, 5'(i), 16'h00a5);
      `CHK("id_blocked", 3'b110, r)
    end
    cyc(1'b0, 1'b0, 2'd0, 5'h13, 16'h0000);
    `CHK("odd_id", 4'h6, {ok, r})
    creg(8'h20, 8'h20);
    cyc(1'b1, 1'b1, 2'd1, 5'h1e, 16'h1234);
    `CHK("id_write", 3'b011, r)
    cyc(1'b1, 1'b0, 2'd0, 5'h14, 16'h0034);
    `CHK("id_no_we", 3'b110, r)
    config_power_down = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("standby", 3'b010, {standby_bit, clock_stop, osc_stop})
    cyc(1'b1, 1'b0, 2'd0, 5'h0e, 16'h0010);
    cyc(1'b1, 1'b0, 2'd0, 5'h07, 16'h0020);
    `CHK("standby_bit_keep", 1'b0, wdat[13])
    `CHK("shutdown", 3'b001, {standby_bit, clock_stop, osc_stop})
    config_power_down = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("wake", 3'b100, {standby_bit, clock_stop, osc_stop})
    cyc(1'b1, 1'b0, 2'd0, 5'h06, 16'h0080);
    `CHK("hold", 4'he, {link_ctrl_hold, xcvr_power_down, lan_init, xcvr_init})
    creg(8'he0, 8'he0);
    soft_card_reset = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("soft", 9'h00f, {io_card_active, perm, link_ctrl_hold, ccr_init,
                          ccr_init_keep_soft, xcvr_init, lan_init})
    soft_card_reset = 1'b0;
    enter();
    creg(8'he0, 8'he0);
    hard_reset = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("hard", 9'h00b, {io_card_active, perm, link_ctrl_hold, ccr_init,
                          ccr_init_keep_soft, xcvr_init, lan_init})
    hard_reset = 1'b0;
    repeat (5) @(negedge clk);
    complete_run();
  end
endmodule
